// ===== include/dce_pkg.sv
package dce_pkg;
  // Stream characters: escape prefix, parameter end, reply marks
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  // Command letters following the prefix
  localparam logic [7:0] CMD_ABORT_GFX = 8'h4B;
  localparam logic [7:0] CMD_IO_RESET = 8'h52;
  localparam logic [7:0] CMD_IDENTIFY = 8'h41;
  localparam logic [7:0] CMD_END_DISC = 8'h55;
  localparam logic [7:0] CMD_ABORT_CTL = 8'h4A;
  localparam logic [7:0] CMD_HS_SELECT = 8'h50;
  localparam logic [7:0] CMD_MEM_ALLOC = 8'h54;
  // Register offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_EXT = 4'h4;
  localparam logic [3:0] A_ISTAT = 4'h8;
  localparam logic [3:0] A_IMASK = 4'hC;
  // Field positions
  localparam int CTRL_HS_EN = 0;
  localparam int CTRL_HS_LO = 1;
  localparam int EXT_ARMED = 8;
  localparam int EXT_DISCARD = 9;
  localparam int EV_ABORT = 0;
  localparam int EV_RESET = 1;
  localparam int EV_IDENT = 2;
  localparam int EV_UNDISC = 3;
  localparam int EV_DISC = 4;
  localparam int NEV = 5;
  // Identification reply; model and revision values are arbitrary
  localparam logic [39:0] ID_MODEL = 40'h44_4556_3031;
  localparam logic [15:0] ID_REV = 16'h3031;
  localparam logic [3:0] ID_LAST = 4'h8;
  // Parameter skip target
  typedef enum logic [1:0] {SK_NONE, SK_HS, SK_MEM} dce_skip_t;
  // Command interpreter states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ESC1, ST_ESC2, ST_SKIP, ST_RST_J, ST_RST_K, ST_RST_P, ST_RST_T
  } dce_state_t;

  // Reply character at a given index
  function automatic logic [7:0] dce_id_char(input logic [3:0] i);
    case (i)
      4'h0: dce_id_char = ID_MODEL[39:32];
      4'h1: dce_id_char = ID_MODEL[31:24];
      4'h2: dce_id_char = ID_MODEL[23:16];
      4'h3: dce_id_char = ID_MODEL[15:8];
      4'h4: dce_id_char = ID_MODEL[7:0];
      4'h5: dce_id_char = CH_COMMA;
      4'h6: dce_id_char = ID_REV[15:8];
      4'h7: dce_id_char = ID_REV[7:0];
      default: dce_id_char = CH_CR;
    endcase
  endfunction : dce_id_char
endpackage : dce_pkg

// ===== include/dce_id_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dce_id_if;
  logic start; // Begin a reply
  logic abort; // Kill a reply in flight
  logic busy; // Reply in progress
  logic [7:0] rsp_byte; // Reply character
  logic rsp_valid; // Character offered
  logic rsp_ready; // Host takes it
  modport ctl (output start, output abort, output rsp_ready, input busy, input rsp_byte, input rsp_valid);
  modport gen (input start, input abort, input rsp_ready, output busy, output rsp_byte, output rsp_valid);
endinterface : dce_id_if
`default_nettype wire

// ===== hw/dce_ident.sv
`timescale 1ns/100ps
`default_nettype none
module dce_ident (
  input wire logic clock,
  input wire logic arst_n,
  dce_id_if.gen id
);
  // All reply state
  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    logic [7:0] chr;
    logic valid;
  } dce_id_st_t;

  dce_id_st_t q, d;

  // Next reply state
  always_comb begin
    d = q;
    if (id.abort) begin
      // Abort wins over everything
      d.busy = 1'b0;
      d.valid = 1'b0;
    end else if (id.start && !q.busy) begin
      d.busy = 1'b1;
      d.idx = 4'h0;
      d.chr = dce_pkg::dce_id_char(4'h0);
      d.valid = 1'b1;
    end else if (q.valid && id.rsp_ready) begin
      if (q.idx == dce_pkg::ID_LAST) begin
        d.busy = 1'b0;
        d.valid = 1'b0;
      end else begin
        d.idx = q.idx + 4'h1;
        d.chr = dce_pkg::dce_id_char(q.idx + 4'h1);
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign id.busy = q.busy;
  assign id.rsp_byte = q.chr;
  assign id.rsp_valid = q.valid;

  // Reply ends in the terminator after model, comma, revision
  id_term_a: assert property (@(posedge clock) disable iff (!arst_n)
    q.valid && q.idx == dce_pkg::ID_LAST |-> q.chr == dce_pkg::CH_CR)
    else $error("reply not terminated");
  id_comma_a: assert property (@(posedge clock) disable iff (!arst_n)
    q.valid && q.idx == 4'h5 |-> q.chr == dce_pkg::CH_COMMA)
    else $error("missing comma");
  id_full_c: cover property (@(posedge clock) disable iff (!arst_n)
    q.valid && q.idx == dce_pkg::ID_LAST && id.rsp_ready);
endmodule : dce_ident
`default_nettype wire

// ===== hw/dce_top.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Abort graphics drops partial and buffered instructions
// - Current vector finishes, other scheduled vectors cancelled
// - Abort graphics flushes buffer, resets parser
// - Serial block-checked data also dropped on abort
// - IO reset stops control, partial instruction, parser
// - IO reset reverts handshake to panel choice
// - IO reset empties buffers, restores memory split
// - IO reset equals abort-control, abort, handshake, memory
// - Identify executes at once, bypassing buffer
// - Reply: model, comma, revision, terminator
// - Discard armed by key, active after group query
// - Active discard throws away graphics data
// - End discard stops dropping, clears status bit 9
module dce_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] gfx_byte,
  output logic gfx_valid,
  input wire logic gfx_ready,
  output logic buf_flush,
  output logic parser_reset,
  output logic vec_cancel,
  input wire logic serial_cfg,
  input wire logic blk_chk_en,
  output logic blk_discard,
  output logic ctrl_abort,
  output logic hs_default,
  output logic mem_default,
  input wire logic [1:0] hs_panel,
  output logic [1:0] hs_mode,
  input wire logic panel_escape,
  input wire logic gcq_done,
  output logic [7:0] ctrl_code,
  output logic ctrl_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // All interpreter state in one word
  typedef struct packed {
    dce_pkg::dce_state_t st;
    dce_pkg::dce_skip_t skip;
    logic had_par; // Parameter seen before colon
    logic in_rdy;
    logic [7:0] gbyte;
    logic gvalid;
    logic flush;
    logic preset;
    logic vcancel;
    logic blkdrop;
    logic cabort;
    logic hsdef;
    logic memdef;
    logic [7:0] ccode;
    logic cvalid;
    logic armed; // Escape key seen
    logic disc; // Discard active
    logic hs_en; // Program-chosen handshake
    logic [1:0] hs_prog;
    logic [1:0] hs_out;
    logic [dce_pkg::NEV-1:0] istat;
    logic [dce_pkg::NEV-1:0] imask;
    logic irq;
    logic [31:0] rdata;
    logic id_start;
    logic id_abort;
  } dce_top_st_t;

  dce_top_st_t q, d;
  dce_id_if id_bus ();

  // Reply generator sits outside the graphics path
  dce_ident u_ident (
    .clock(clock),
    .arst_n(arst_n),
    .id(id_bus.gen)
  );

  assign id_bus.start = q.id_start;
  assign id_bus.abort = q.id_abort;
  assign id_bus.rsp_ready = rsp_ready;

  // Byte accepted this cycle
  logic take;
  assign take = in_valid && q.in_rdy;

  // Next state
  always_comb begin
    logic do_abort;
    logic do_cabort;
    logic do_hsdef;
    logic [dce_pkg::NEV-1:0] ev;
    logic [dce_pkg::NEV-1:0] wclr;
    do_abort = 1'b0;
    do_cabort = 1'b0;
    do_hsdef = 1'b0;
    ev = '0;
    wclr = '0;
    d = q;
    // Pulses last one cycle
    d.flush = 1'b0;
    d.preset = 1'b0;
    d.vcancel = 1'b0;
    d.blkdrop = 1'b0;
    d.cabort = 1'b0;
    d.hsdef = 1'b0;
    d.memdef = 1'b0;
    d.cvalid = 1'b0;
    d.id_start = 1'b0;
    d.id_abort = 1'b0;
    d.rdata = '0;
    // Downstream took the held byte
    if (q.gvalid && gfx_ready) begin
      d.gvalid = 1'b0;
    end
    // Key arms; the group query fires it
    if (panel_escape) begin
      d.armed = 1'b1;
    end
    if (q.armed && gcq_done) begin
      d.disc = 1'b1;
      d.armed = 1'b0;
      ev[dce_pkg::EV_DISC] = 1'b1;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        dce_pkg::A_CTRL: begin
          d.hs_en = reg_wdata[dce_pkg::CTRL_HS_EN];
          d.hs_prog = reg_wdata[dce_pkg::CTRL_HS_LO +: 2];
        end
        dce_pkg::A_ISTAT: wclr = reg_wdata[dce_pkg::NEV-1:0];
        dce_pkg::A_IMASK: d.imask = reg_wdata[dce_pkg::NEV-1:0];
        default: ;
      endcase
    end
    // Register reads, data next cycle
    if (reg_rd) begin
      case (reg_addr)
        dce_pkg::A_CTRL: begin
          d.rdata[dce_pkg::CTRL_HS_EN] = q.hs_en;
          d.rdata[dce_pkg::CTRL_HS_LO +: 2] = q.hs_prog;
        end
        dce_pkg::A_EXT: begin
          d.rdata[dce_pkg::EXT_ARMED] = q.armed;
          d.rdata[dce_pkg::EXT_DISCARD] = q.disc;
        end
        dce_pkg::A_ISTAT: d.rdata[dce_pkg::NEV-1:0] = q.istat;
        dce_pkg::A_IMASK: d.rdata[dce_pkg::NEV-1:0] = q.imask;
        default: ;
      endcase
    end
    // Escape recognition ahead of the buffer
    case (q.st)
      dce_pkg::ST_IDLE: begin
        if (take) begin
          if (in_byte == dce_pkg::CH_ESC) begin
            d.st = dce_pkg::ST_ESC1;
          end else if (!q.disc) begin
            d.gbyte = in_byte;
            d.gvalid = 1'b1;
          end
          // Else dropped while discarding
        end
      end
      dce_pkg::ST_ESC1: begin
        if (take) begin
          // Broken prefix: both bytes dropped
          d.st = (in_byte == dce_pkg::CH_DOT) ? dce_pkg::ST_ESC2 : dce_pkg::ST_IDLE;
        end
      end
      dce_pkg::ST_ESC2: begin
        if (take) begin
          d.st = dce_pkg::ST_IDLE;
          case (in_byte)
            dce_pkg::CMD_ABORT_GFX: do_abort = 1'b1;
            dce_pkg::CMD_IO_RESET: d.st = dce_pkg::ST_RST_J;
            dce_pkg::CMD_IDENTIFY: begin
              // Immediate, never queued
              d.id_start = !id_bus.busy;
              ev[dce_pkg::EV_IDENT] = 1'b1;
            end
            dce_pkg::CMD_END_DISC: begin
              // A key press or trigger in the same cycle still counts
              d.disc = q.armed && gcq_done;
              d.armed = d.armed && panel_escape;
              ev[dce_pkg::EV_UNDISC] = 1'b1;
            end
            dce_pkg::CMD_ABORT_CTL: do_cabort = 1'b1;
            dce_pkg::CMD_HS_SELECT: begin
              d.st = dce_pkg::ST_SKIP;
              d.skip = dce_pkg::SK_HS;
              d.had_par = 1'b0;
            end
            dce_pkg::CMD_MEM_ALLOC: begin
              d.st = dce_pkg::ST_SKIP;
              d.skip = dce_pkg::SK_MEM;
              d.had_par = 1'b0;
            end
            default: begin
              // Left to other control logic
              d.ccode = in_byte;
              d.cvalid = 1'b1;
            end
          endcase
        end
      end
      dce_pkg::ST_SKIP: begin
        if (take) begin
          if (in_byte == dce_pkg::CH_COLON) begin
            d.st = dce_pkg::ST_IDLE;
            // Only the bare form takes defaults
            if (!q.had_par && q.skip == dce_pkg::SK_HS) begin
              do_hsdef = 1'b1;
            end
            if (!q.had_par && q.skip == dce_pkg::SK_MEM) begin
              d.memdef = 1'b1;
            end
          end else begin
            d.had_par = 1'b1;
          end
        end
      end
      // Reset runs its four steps in order
      dce_pkg::ST_RST_J: begin
        do_cabort = 1'b1;
        d.st = dce_pkg::ST_RST_K;
      end
      dce_pkg::ST_RST_K: begin
        do_abort = 1'b1;
        d.st = dce_pkg::ST_RST_P;
      end
      dce_pkg::ST_RST_P: begin
        do_hsdef = 1'b1;
        d.st = dce_pkg::ST_RST_T;
      end
      dce_pkg::ST_RST_T: begin
        d.memdef = 1'b1;
        d.st = dce_pkg::ST_IDLE;
        ev[dce_pkg::EV_RESET] = 1'b1;
      end
      default: d.st = dce_pkg::ST_IDLE;
    endcase
    // Abort graphics effects
    if (do_abort) begin
      d.flush = 1'b1;
      d.preset = 1'b1;
      d.vcancel = 1'b1;
      d.blkdrop = serial_cfg && blk_chk_en;
      d.gvalid = 1'b0;
      ev[dce_pkg::EV_ABORT] = 1'b1;
    end
    // Abort device control stops the reply too
    if (do_cabort) begin
      d.cabort = 1'b1;
      d.id_abort = 1'b1;
    end
    // Program handshake choice forgotten
    if (do_hsdef) begin
      d.hsdef = 1'b1;
      d.hs_en = 1'b0;
    end
    d.hs_out = d.hs_en ? d.hs_prog : hs_panel;
    // No new byte while one is held or a reset runs
    d.in_rdy = !d.gvalid && (d.st == dce_pkg::ST_IDLE || d.st == dce_pkg::ST_ESC1 ||
      d.st == dce_pkg::ST_ESC2 || d.st == dce_pkg::ST_SKIP);
    // Sticky events, set wins over a write-one clear
    d.istat = (q.istat & ~wclr) | ev;
    d.irq = |(d.istat & d.imask);
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come from the state word, the reply from the generator
  assign in_ready = q.in_rdy;
  assign gfx_byte = q.gbyte;
  assign gfx_valid = q.gvalid;
  assign buf_flush = q.flush;
  assign parser_reset = q.preset;
  assign vec_cancel = q.vcancel;
  assign blk_discard = q.blkdrop;
  assign ctrl_abort = q.cabort;
  assign hs_default = q.hsdef;
  assign mem_default = q.memdef;
  assign hs_mode = q.hs_out;
  assign ctrl_code = q.ccode;
  assign ctrl_valid = q.cvalid;
  assign rsp_byte = id_bus.rsp_byte;
  assign rsp_valid = id_bus.rsp_valid;
  assign reg_rdata = q.rdata;
  assign irq = q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Command letter taken in the final prefix state
  logic cmd_k;
  logic cmd_r;
  logic cmd_a;
  logic cmd_u;
  assign cmd_k = take && q.st == dce_pkg::ST_ESC2 && in_byte == dce_pkg::CMD_ABORT_GFX;
  assign cmd_r = take && q.st == dce_pkg::ST_ESC2 && in_byte == dce_pkg::CMD_IO_RESET;
  assign cmd_a = take && q.st == dce_pkg::ST_ESC2 && in_byte == dce_pkg::CMD_IDENTIFY;
  assign cmd_u = take && q.st == dce_pkg::ST_ESC2 && in_byte == dce_pkg::CMD_END_DISC;

  abort_flush_a: assert property (cmd_k |=> buf_flush && !gfx_valid)
    else $error("abort did not flush");
  vec_cancel_a: assert property (cmd_k |=> vec_cancel ##1 !vec_cancel)
    else $error("vector cancel not one pulse");
  parser_rst_a: assert property (buf_flush |-> parser_reset && vec_cancel)
    else $error("parser not reset with flush");
  blk_drop_a: assert property (cmd_k |=> blk_discard == $past(serial_cfg && blk_chk_en))
    else $error("block data drop wrong");
  reset_seq_a: assert property (cmd_r |=> ##1 ctrl_abort ##1 buf_flush ##1 hs_default ##1 mem_default)
    else $error("reset sequence out of order");
  reset_stall_a: assert property (cmd_r |=> !in_ready [*4])
    else $error("input taken during reset");
  hs_revert_a: assert property (hs_default |-> hs_mode == $past(hs_panel))
    else $error("handshake not panel choice");
  mem_def_a: assert property (cmd_r |-> ##5 mem_default)
    else $error("memory split not restored");
  ident_now_a: assert property (cmd_a && !id_bus.busy |=> ##1 rsp_valid)
    else $error("identify not immediate");
  disc_on_a: assert property ($rose(q.disc) |-> $past(gcq_done && q.armed))
    else $error("discard without group query");
  disc_drop_a: assert property (q.disc && take && q.st == dce_pkg::ST_IDLE |=> !gfx_valid)
    else $error("graphics passed during discard");
  end_disc_a: assert property (cmd_u && !(q.armed && gcq_done) |=>
    !q.disc ##1 !reg_rdata[dce_pkg::EXT_DISCARD])
    else $error("discard not ended");
  esc_block_a: assert property (gfx_valid |-> gfx_byte != dce_pkg::CH_ESC)
    else $error("escape reached graphics buffer");

  abort_c: cover property (cmd_k ##1 buf_flush);
  reset_c: cover property (cmd_r ##5 mem_default);
  disc_c: cover property ($rose(q.disc) ##[1:50] cmd_u);
endmodule : dce_top
`default_nettype wire

// ===== sim/dce_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host computer on the far side of the byte stream and the reply stream
module dce_host (
  input wire logic clock,
  input wire logic arst_n,
  output logic [7:0] in_byte,
  output logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_valid,
  output logic rsp_ready
);
  localparam logic [7:0] QRY_SPACE = 8'h4C; // Buffer-space query letter
  logic [1:0] rx_mode; // Reply pacing: 0 prompt, 1 slow, 2 stalled
  logic [71:0] rx_word; // Reply characters, oldest in the top byte
  int rx_n; // Reply characters taken

  initial begin
    in_byte = 8'h00;
    in_valid = 1'b0;
    rx_mode = 2'h0;
  end

  // Reply capture; slow pacing takes one character every other cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsp_ready <= 1'b0;
    end else begin
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        rx_word <= {rx_word[63:0], rsp_byte};
        rx_n <= rx_n + 1;
      end
      rsp_ready <= (rx_mode == 2'h2) ? 1'b0 : ((rx_mode == 2'h1) ? ~rsp_ready : 1'b1);
    end
  end

  // Forget earlier replies; only called while no reply is moving
  task automatic clear_rx();
    rx_n = 0;
    rx_word = '0;
  endtask : clear_rx

  // Bytes in order, each held until an edge with in_ready high
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      in_byte <= b[i];
      in_valid <= 1'b1;
      do @(posedge clock); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_byte <= ~b[b.size()-1]; // Released line must not show the last byte
  endtask : send

  // One escape-prefixed command without parameters
  task automatic esc(input logic [7:0] letter);
    send('{dce_pkg::CH_ESC, dce_pkg::CH_DOT, letter});
  endtask : esc

  // Reset, then ask for buffer space before sending anything else
  task automatic io_reset_and_query();
    esc(dce_pkg::CMD_IO_RESET);
    @(posedge clock); // Let the valid line fall before the next command
    esc(QRY_SPACE);
  endtask : io_reset_and_query
endmodule : dce_host
`default_nettype wire

// ===== sim/dce_top_test.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the escape command interpreter
module dce_top_test;
  logic clock, arst_n, in_valid, in_ready, gfx_valid, gfx_ready, buf_flush, parser_reset, vec_cancel;
  logic serial_cfg, blk_chk_en, blk_discard, ctrl_abort, hs_default, mem_default, panel_escape, gcq_done;
  logic ctrl_valid, rsp_valid, rsp_ready, reg_wr, reg_rd, irq;
  logic [7:0] in_byte, gfx_byte, ctrl_code, rsp_byte;
  logic [1:0] hs_panel, hs_mode;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] pulses; // One-cycle effects, one bit each
  logic [7:0] last_gfx; // Last byte handed to the buffer
  int cnt [8]; // Pulses seen per effect
  int first [8]; // Cycle of the first pulse per effect, 0 if none
  int cyc, n_gfx, n_errors, total_checks;
  localparam int P_FL = 0, P_CA = 4, P_HS = 5, P_MEM = 6; // Bit positions in pulses

  dce_top u_dce_top (.clock(clock), .arst_n(arst_n), .in_byte(in_byte), .in_valid(in_valid),
    .in_ready(in_ready), .gfx_byte(gfx_byte), .gfx_valid(gfx_valid), .gfx_ready(gfx_ready),
    .buf_flush(buf_flush), .parser_reset(parser_reset), .vec_cancel(vec_cancel), .serial_cfg(serial_cfg),
    .blk_chk_en(blk_chk_en), .blk_discard(blk_discard), .ctrl_abort(ctrl_abort), .hs_default(hs_default),
    .mem_default(mem_default), .hs_panel(hs_panel), .hs_mode(hs_mode), .panel_escape(panel_escape),
    .gcq_done(gcq_done), .ctrl_code(ctrl_code), .ctrl_valid(ctrl_valid), .rsp_byte(rsp_byte),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  dce_host u_dce_host (.clock(clock), .arst_n(arst_n), .in_byte(in_byte), .in_valid(in_valid),
    .in_ready(in_ready), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

  assign pulses = {ctrl_valid, mem_default, hs_default, ctrl_abort, blk_discard, vec_cancel, parser_reset, buf_flush};

  // Count effect pulses and buffer hand-overs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++) begin
      if (pulses[i] === 1'b1) begin
        cnt[i] <= cnt[i] + 1;
        if (first[i] == 0) first[i] <= cyc;
      end
    end
    if (gfx_valid === 1'b1 && gfx_ready === 1'b1) begin
      n_gfx <= n_gfx + 1;
      last_gfx <= gfx_byte;
    end
  end

  // Clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Value seen against value expected
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Verdict, then end of run
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Register write, one strobe cycle
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_w

  // Register read; data stands only in the cycle after the strobe
  task automatic reg_r(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : reg_r

  // Forget earlier pulses; called only while the block is quiet
  task automatic clear_mon();
    foreach (cnt[i]) cnt[i] = 0;
    foreach (first[i]) first[i] = 0;
    n_gfx = 0;
  endtask : clear_mon

  // Each effect pulsed once if its mask bit is set, else never
  task automatic expect_pulses(input logic [7:0] mask);
    for (int i = 0; i < 8; i++) check($sformatf("pulse %0d", i), cnt[i], mask[i]);
  endtask : expect_pulses

  // State after reset: registers clear, panel handshake in force
  task automatic t_reset();
    logic [31:0] d;
    logic [3:0] adr [5] = '{dce_pkg::A_CTRL, dce_pkg::A_EXT, dce_pkg::A_ISTAT, dce_pkg::A_IMASK, 4'h2};
    check("hs_mode", hs_mode, hs_panel);
    check("irq", irq, 1'b0);
    foreach (adr[i]) begin
      reg_r(adr[i], d);
      check("reset reg", d, 32'h0000_0000);
    end
  endtask : t_reset

  // Abort with a held byte first, block checking on, with and without serial config
  task automatic t_abort();
    logic [31:0] d;
    serial_cfg <= 1'b1;
    blk_chk_en <= 1'b1;
    gfx_ready <= 1'b0;
    u_dce_host.send('{8'h50});
    tick(3);
    check("gfx held", {gfx_valid, in_ready, gfx_byte}, {2'b10, 8'h50});
    gfx_ready <= 1'b1;
    tick(2);
    check("gfx taken", n_gfx, 1);
    clear_mon();
    u_dce_host.esc(dce_pkg::CMD_ABORT_GFX);
    tick(4);
    expect_pulses(8'h0F);
    check("esc forwarded", n_gfx, 0);
    serial_cfg <= 1'b0;
    clear_mon();
    u_dce_host.esc(dce_pkg::CMD_ABORT_GFX);
    tick(4);
    expect_pulses(8'h07);
    reg_r(dce_pkg::A_ISTAT, d);
    check("abort event", d[dce_pkg::EV_ABORT], 1'b1);
    reg_w(dce_pkg::A_IMASK, 32'h0000_0001);
    tick(2);
    check("irq set", irq, 1'b1);
    reg_w(dce_pkg::A_ISTAT, 32'h0000_0001);
    tick(2);
    check("irq clear", irq, 1'b0);
    reg_w(dce_pkg::A_IMASK, 32'h0000_0000);
    tick(1);
  endtask : t_abort

  // I/O reset while a reply stalls; effects, their order, handshake
  task automatic t_io_reset();
    reg_w(dce_pkg::A_CTRL, 32'h0000_0005);
    tick(2);
    check("hs program", hs_mode, 2'b10);
    hs_panel <= 2'b11;
    u_dce_host.rx_mode = 2'h2;
    u_dce_host.clear_rx();
    u_dce_host.esc(dce_pkg::CMD_IDENTIFY);
    tick(4);
    check("reply pending", rsp_valid, 1'b1);
    clear_mon();
    u_dce_host.io_reset_and_query();
    tick(8);
    check("reply killed", rsp_valid, 1'b0);
    u_dce_host.rx_mode = 2'h0;
    tick(4);
    check("reply chars", u_dce_host.rx_n, 0);
    expect_pulses(8'hF7);
    check("order", {first[P_CA] < first[P_FL], first[P_FL] < first[P_HS], first[P_HS] < first[P_MEM]}, 3'b111);
    check("hs panel", hs_mode, 2'b11);
    check("query letter", ctrl_code, 8'h4C);
  endtask : t_io_reset

  // Only parameterless handshake and memory commands give defaults
  task automatic t_params();
    clear_mon();
    u_dce_host.send('{dce_pkg::CH_ESC, dce_pkg::CH_DOT, dce_pkg::CMD_HS_SELECT, dce_pkg::CH_COLON,
      dce_pkg::CH_ESC, dce_pkg::CH_DOT, dce_pkg::CMD_MEM_ALLOC, dce_pkg::CH_COLON,
      dce_pkg::CH_ESC, dce_pkg::CH_DOT, dce_pkg::CMD_HS_SELECT, 8'h31, dce_pkg::CH_COLON});
    tick(6);
    expect_pulses(8'h60);
  endtask : t_params

  // Identification with a slow host, never entering the buffer
  task automatic t_identify();
    logic [31:0] d;
    reg_w(dce_pkg::A_ISTAT, 32'h0000_001F); // Old events would hide a missing one
    u_dce_host.rx_mode = 2'h1;
    u_dce_host.clear_rx();
    clear_mon();
    u_dce_host.esc(dce_pkg::CMD_IDENTIFY);
    for (int i = 0; i < 300 && u_dce_host.rx_n < 9; i++) @(posedge clock);
    check("reply", u_dce_host.rx_word, {dce_pkg::ID_MODEL, dce_pkg::CH_COMMA, dce_pkg::ID_REV, dce_pkg::CH_CR});
    check("reply gfx", n_gfx, 0);
    reg_r(dce_pkg::A_ISTAT, d);
    check("ident event", d[dce_pkg::EV_IDENT], 1'b1);
  endtask : t_identify

  // Discard armed by key, active after group query, ended by command
  task automatic t_discard();
    logic [31:0] d;
    clear_mon();
    panel_escape <= 1'b1;
    tick(1);
    panel_escape <= 1'b0;
    tick(2);
    reg_r(dce_pkg::A_EXT, d);
    check("armed", d, 32'h0000_0100);
    u_dce_host.send('{8'h58});
    tick(3);
    check("armed passes", n_gfx, 1);
    gcq_done <= 1'b1;
    tick(1);
    gcq_done <= 1'b0;
    tick(2);
    reg_r(dce_pkg::A_EXT, d);
    check("active", d[dce_pkg::EXT_DISCARD], 1'b1);
    u_dce_host.send('{8'h59, 8'h5A});
    tick(3);
    check("dropped", n_gfx, 1);
    u_dce_host.esc(dce_pkg::CMD_END_DISC);
    tick(2);
    reg_r(dce_pkg::A_EXT, d);
    check("ended", d[dce_pkg::EXT_DISCARD], 1'b0);
    u_dce_host.send('{8'h57});
    tick(3);
    check("resumed", {n_gfx[7:0], last_gfx}, {8'h02, 8'h57});
    reg_r(dce_pkg::A_ISTAT, d);
    check("disc events", d[dce_pkg::EV_DISC:dce_pkg::EV_UNDISC], 2'b11);
  endtask : t_discard

  // Main sequence
  initial begin
    arst_n = 1'b0;
    gfx_ready = 1'b1;
    serial_cfg = 1'b0;
    blk_chk_en = 1'b0;
    hs_panel = 2'b01;
    panel_escape = 1'b0;
    gcq_done = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    tick(3);
    t_reset();
    t_abort();
    t_io_reset();
    t_params();
    t_identify();
    t_discard();
    close_out();
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out();
  end
endmodule : dce_top_test
`default_nettype wire
